// ### logic/cid_decoder.sv
// Major-opcode decoder with sub-field exception resolution and Wishbone regs
//
// The implementer's own choices: the address map and the Wishbone slave port.
`timescale 1ns/100ps
`default_nettype none

// Operation
// - Reserved encodings raise reserved instruction
// - Field classes query a further field
// - Higher-level encodings, column 111, raise reserved
// - Compat-illegal runs in kernel, debug, wide
// - Compat-illegal unusable coprocessor raises unusable
// - Unimplemented partner encodings raise reserved/unusable
// - Omitted debug-support encodings raise reserved
// - Unimplemented extension encodings raise reserved
// - Prefixed non-extensible instruction raises reserved
// - Row 00 column mapping
// - Row 01 column mapping
// - Row 10 column mapping
// - Row 11 column mapping
// - Link class selects on bit 26
module cid_decoder
    import cid_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Fetch stage
    input wire cid_fetch_t fetch_i,
    // Sub-field decoder
    output cid_sub_req_t sub_req_o,
    input wire cid_sub_rsp_t sub_rsp_i,
    // Decode result
    output cid_dec_t dec_o,
    // Wishbone slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [3:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o
);

    ////////////////////////////////////////////////////////////////////////
    // Functions

    // Major opcode table lookup
    function automatic cid_op_t major_op(input logic [4:0] maj);
        cid_op_t r;
        r = op_none;
        case (maj)
            5'h00: r = op_stack_rel_add_imm;
            5'h03: r = op_jump_and_link;
            5'h04: r = op_branch_if_zero;
            5'h05: r = op_branch_if_nonzero;
            5'h06: r = op_shift_class;
            5'h08: r = op_two_reg_add_imm_class;
            5'h09: r = op_add_imm_8bit;
            5'h0a: r = op_set_less_imm;
            5'h0b: r = op_set_less_imm_unsigned;
            5'h0c: r = op_eight_bit_function_class;
            5'h0d: r = op_load_immediate;
            5'h0e: r = op_compare_immediate;
            5'h10: r = op_load_byte_signed;
            5'h11: r = op_load_half_signed;
            5'h12: r = op_stack_rel_load_word;
            5'h13: r = op_load_word;
            5'h14: r = op_load_byte_unsigned;
            5'h15: r = op_load_half_unsigned;
            5'h16: r = op_pc_rel_load_word;
            5'h18: r = op_store_byte;
            5'h19: r = op_store_half;
            5'h1a: r = op_stack_rel_store_word;
            5'h1b: r = op_store_word;
            5'h1c: r = op_three_reg_class;
            5'h1d: r = op_reg_reg_class;
            5'h1e: r = op_ext_prefix;
            default: r = op_none;
        endcase
        return r;
    endfunction

    // Field classes that need the sub-field decoder
    function automatic logic is_class(input cid_op_t op);
        return (op == op_shift_class) || (op == op_two_reg_add_imm_class) ||
            (op == op_eight_bit_function_class) ||
            (op == op_three_reg_class) || (op == op_reg_reg_class);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // State

    typedef struct packed {
        logic [CTRL_WIDTH-1:0] ctrl;
        cid_dec_t dec;
        logic [15:0] ri_count;
        logic [15:0] cu_count;
        cid_dec_t last; // Last valid decode, read back as status
        logic ack;
        logic [31:0] rdata;
    } cid_state_t;

    cid_state_t st; // Registered state
    cid_state_t next_st; // Next state
    logic [15:0] first_hw; // Halfword holding the major opcode
    logic [4:0] maj; // Major opcode of first halfword
    logic [4:0] inner; // Opcode after any prefix
    logic prefixed; // Pair starts with the extension prefix
    cid_op_t op; // Operation picked
    logic exc_ri; // Reserved instruction
    logic exc_cu; // Coprocessor unusable
    logic cop_ok; // Addressed coprocessor usable
    logic priv; // Kernel, debug or wide mode
    logic bus_req; // New Wishbone request
    logic [31:0] wmask; // Byte-lane write mask

    ////////////////////////////////////////////////////////////////////////
    // Field extraction and major decode

    always_comb
    begin
        // Long pairs carry the opcode in the upper halfword
        first_hw = fetch_i.pair ? fetch_i.instr[31:16] : fetch_i.instr[15:0];
        maj = first_hw[MAJ_HI:MAJ_LO];
        prefixed = fetch_i.pair && (maj == MAJ_PREFIX);
        inner = prefixed ? fetch_i.instr[MAJ_HI:MAJ_LO] : maj;
        op = major_op(inner);
        // Link class picks its variant from the x bit
        if (op == op_jump_and_link)
        begin
            op = fetch_i.instr[LINK_X_BIT] ? op_jump_link_switch_isa
                : op_jump_and_link;
        end
    end

    // Query out to the sub-field decoder; same-cycle answer expected
    always_comb
    begin
        sub_req_o.valid = fetch_i.valid && is_class(op);
        sub_req_o.op = op;
        sub_req_o.extended = prefixed;
        sub_req_o.hw = prefixed ? fetch_i.instr[15:0] : first_hw;
    end

    ////////////////////////////////////////////////////////////////////////
    // Exception resolution

    always_comb
    begin
        priv = st.ctrl[CTRL_KERNEL] || st.ctrl[CTRL_DEBUG] ||
            st.ctrl[CTRL_WIDE];
        cop_ok = st.ctrl[CTRL_COP_LO + int'(sub_rsp_i.cop_num)];
        exc_ri = 1'b0;
        exc_cu = 1'b0;
        if (inner[2:0] == COL_HIGHER)
        begin
            // Top column is only valid at a higher level
            exc_ri = 1'b1;
        end
        else if (op == op_none)
        begin
            // Empty table slots are treated as reserved
            exc_ri = 1'b1;
        end
        else if (prefixed && ((inner == MAJ_LINK) || (inner == MAJ_PREFIX)))
        begin
            // Link class and prefix itself refuse a prefix
            exc_ri = 1'b1;
        end
        else if (!fetch_i.pair && ((maj == MAJ_LINK) || (maj == MAJ_PREFIX)))
        begin
            // Two-halfword forms without their second half
            exc_ri = 1'b1;
        end
        else if (op == op_ext_prefix)
        begin
            // A lone prefix cannot stand as an instruction
            exc_ri = 1'b1;
        end
        else if (is_class(op))
        begin
            case (sub_rsp_i.mark)
                mk_reserved: exc_ri = 1'b1;
                mk_higher: exc_ri = 1'b1;
                mk_compat:
                begin
                    // Legal unless compat mode outside privileged modes
                    if (st.ctrl[CTRL_COMPAT] && !priv)
                    begin
                        exc_cu = sub_rsp_i.is_cop && !cop_ok;
                        exc_ri = !(sub_rsp_i.is_cop && !cop_ok);
                    end
                end
                mk_partner:
                begin
                    if (!sub_rsp_i.impl)
                    begin
                        exc_cu = sub_rsp_i.is_cop && !cop_ok;
                        exc_ri = !(sub_rsp_i.is_cop && !cop_ok);
                    end
                end
                mk_debug: exc_ri = !st.ctrl[CTRL_DBGI];
                mk_ase: exc_ri = !st.ctrl[CTRL_ASE];
                default: exc_ri = 1'b0;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Next-state logic: decode stage and register file

    always_comb
    begin
        next_st = st;
        bus_req = cyc_i && stb_i && !st.ack;
        wmask = {{8{sel_i[3]}}, {8{sel_i[2]}}, {8{sel_i[1]}}, {8{sel_i[0]}}};
        // Decode result is one stage behind fetch
        next_st.dec.valid = fetch_i.valid;
        next_st.dec.op = fetch_i.valid ? op : op_none;
        next_st.dec.exc_ri = fetch_i.valid && exc_ri;
        next_st.dec.exc_cu = fetch_i.valid && exc_cu;
        // Faulting instruction must not touch program state
        next_st.dec.commit = fetch_i.valid && !exc_ri && !exc_cu;
        next_st.last = fetch_i.valid ? next_st.dec : st.last; // Status copy
        // Counters saturate so software never sees a wrap
        if (fetch_i.valid && exc_ri && (st.ri_count != 16'hffff))
        begin
            next_st.ri_count = st.ri_count + 16'h0001;
        end
        if (fetch_i.valid && exc_cu && (st.cu_count != 16'hffff))
        begin
            next_st.cu_count = st.cu_count + 16'h0001;
        end
        // Ack rises one cycle after the request and falls after
        next_st.ack = bus_req;
        next_st.rdata = 32'h0000_0000;
        if (bus_req && we_i)
        begin
            if (adr_i[3:2] == OFS_CTRL)
            begin
                next_st.ctrl = CTRL_WIDTH'((32'(st.ctrl) & ~wmask) |
                    (dat_i & wmask));
            end
            else if (adr_i[3:2] == OFS_COUNT)
            begin
                // Any write clears both counters; a same-cycle event wins
                next_st.ri_count = (fetch_i.valid && exc_ri) ? 16'h0001
                    : 16'h0000;
                next_st.cu_count = (fetch_i.valid && exc_cu) ? 16'h0001
                    : 16'h0000;
            end
        end
        else if (bus_req)
        begin
            if (adr_i[3:2] == OFS_CTRL)
            begin
                next_st.rdata = 32'(st.ctrl);
            end
            else if (adr_i[3:2] == OFS_STATUS)
            begin
                next_st.rdata = {25'h000_0000, st.last.exc_cu,
                    st.last.exc_ri, st.last.op};
            end
            else if (adr_i[3:2] == OFS_COUNT)
            begin
                next_st.rdata = {st.cu_count, st.ri_count};
            end
            else
            begin
                // Unmapped: acked, reads zero
                next_st.rdata = 32'h0000_0000;
            end
        end
    end

    // State register
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            st <= '0;
            st.ctrl <= CTRL_RESET;
        end
        else
        begin
            st <= next_st;
        end
    end

    // Outputs straight from flops
    assign dec_o = st.dec;
    assign ack_o = st.ack;
    assign dat_o = st.rdata;

    ////////////////////////////////////////////////////////////////////////
    // Assertions

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    // A class fetch whose sub-field answer carries a mark
    sequence s_class(cid_mark_t m);
        fetch_i.valid && sub_req_o.valid && (sub_rsp_i.mark == m);
    endsequence

    // Outcome one cycle later
    sequence s_ri_after;
        ##1 (dec_o.exc_ri && !dec_o.commit && !dec_o.exc_cu);
    endsequence

    chk_reserved_ri: assert property (
        s_class(mk_reserved) |-> s_ri_after)
        else $error("reserved field code not refused");

    chk_class_query: assert property (fetch_i.valid &&
        (fetch_i.instr[15:11] == 5'h1d) && !fetch_i.pair |->
        sub_req_o.valid && (sub_req_o.op == op_reg_reg_class))
        else $error("field class not passed on");

    chk_higher_ri: assert property (fetch_i.valid &&
        !fetch_i.pair && (fetch_i.instr[13:11] == 3'h7) |-> s_ri_after)
        else $error("higher-level opcode not refused");

    chk_compat_priv: assert property (
        s_class(mk_compat) ##0 priv |-> ##1 dec_o.commit)
        else $error("compat encoding refused in privileged mode");

    chk_cop_unusable: assert property (s_class(mk_compat) ##0
        (!priv && st.ctrl[CTRL_COMPAT] && sub_rsp_i.is_cop && !cop_ok) |->
        ##1 (dec_o.exc_cu && !dec_o.exc_ri && !dec_o.commit))
        else $error("unusable coprocessor not flagged");

    chk_partner_miss: assert property (s_class(mk_partner) ##0
        (!sub_rsp_i.impl && !sub_rsp_i.is_cop) |-> s_ri_after)
        else $error("empty partner encoding not refused");

    chk_debug_omit: assert property (s_class(mk_debug) ##0
        !st.ctrl[CTRL_DBGI] |-> s_ri_after)
        else $error("omitted debug encoding not refused");

    chk_ase_absent: assert property (s_class(mk_ase) ##0
        !st.ctrl[CTRL_ASE] |-> s_ri_after)
        else $error("absent extension not refused");

    chk_prefix_nonext: assert property (fetch_i.valid &&
        fetch_i.pair && (fetch_i.instr[31:27] == 5'h1e) &&
        (fetch_i.instr[15:11] == 5'h03) |-> s_ri_after)
        else $error("prefixed link class not refused");

    chk_row_loads: assert property (fetch_i.valid &&
        !fetch_i.pair && (fetch_i.instr[15:11] == 5'h13) |->
        ##1 ((dec_o.op == op_load_word) && dec_o.commit))
        else $error("load word column wrong");

    chk_link_select: assert property (fetch_i.valid &&
        fetch_i.pair && (fetch_i.instr[31:27] == 5'h03) |-> ##1 (dec_o.op ==
        ($past(fetch_i.instr[26]) ? op_jump_link_switch_isa
        : op_jump_and_link)))
        else $error("link variant wrong");

    chk_no_commit: assert property (
        dec_o.exc_ri || dec_o.exc_cu |-> !dec_o.commit)
        else $error("faulting instruction committed");

endmodule // cid_decoder

`default_nettype wire

// ### logic/cid_pkg.sv
// Shared types and constants for the compact instruction major-opcode decoder
package cid_pkg;

    // Major opcode field position in a halfword
    localparam int MAJ_HI = 15;
    localparam int MAJ_LO = 11;
    // Link-class selector bit inside a 32-bit pair
    localparam int LINK_X_BIT = 26;
    // Major opcodes that need special handling
    localparam logic [4:0] MAJ_LINK = 5'h03;
    localparam logic [4:0] MAJ_PREFIX = 5'h1e;
    localparam logic [2:0] COL_HIGHER = 3'h7;

    // Register word offsets (byte address bits 3:2)
    localparam logic [1:0] OFS_CTRL = 2'h0;
    localparam logic [1:0] OFS_STATUS = 2'h1;
    localparam logic [1:0] OFS_COUNT = 2'h2;
    // Control field positions
    localparam int CTRL_COMPAT = 0;
    localparam int CTRL_KERNEL = 1;
    localparam int CTRL_DEBUG = 2;
    localparam int CTRL_WIDE = 3;
    localparam int CTRL_COP_LO = 4;
    localparam int CTRL_ASE = 8;
    localparam int CTRL_DBGI = 9;
    localparam int CTRL_WIDTH = 10;
    localparam logic [CTRL_WIDTH-1:0] CTRL_RESET = 10'h000;

    // Operations and field classes picked at the major opcode
    typedef enum logic [4:0] {
        op_none, op_stack_rel_add_imm, op_jump_and_link,
        op_jump_link_switch_isa, op_branch_if_zero, op_branch_if_nonzero,
        op_shift_class, op_two_reg_add_imm_class, op_add_imm_8bit,
        op_set_less_imm, op_set_less_imm_unsigned,
        op_eight_bit_function_class, op_load_immediate,
        op_compare_immediate, op_load_byte_signed, op_load_half_signed,
        op_stack_rel_load_word, op_load_word, op_load_byte_unsigned,
        op_load_half_unsigned, op_pc_rel_load_word, op_store_byte,
        op_store_half, op_stack_rel_store_word, op_store_word,
        op_three_reg_class, op_reg_reg_class, op_ext_prefix
    } cid_op_t;

    // Marks that a sub-field decoder attaches to its encoding
    typedef enum logic [2:0] {
        mk_none, mk_reserved, mk_higher, mk_compat,
        mk_partner, mk_debug, mk_ase
    } cid_mark_t;

    // Fetch stage request
    typedef struct packed {
        logic valid;
        logic pair;
        logic [31:0] instr;
    } cid_fetch_t;

    // Query to the sub-field decoder
    typedef struct packed {
        logic valid;
        cid_op_t op;
        logic extended;
        logic [15:0] hw;
    } cid_sub_req_t;

    // Answer of the sub-field decoder
    typedef struct packed {
        cid_mark_t mark;
        logic is_cop;
        logic [1:0] cop_num;
        logic impl;
    } cid_sub_rsp_t;

    // Decode result towards pipeline and exception logic
    typedef struct packed {
        logic valid;
        cid_op_t op;
        logic exc_ri;
        logic exc_cu;
        logic commit;
    } cid_dec_t;

endpackage : cid_pkg

// ### test/cid_sub_model.sv
// Behavioural sub-field decoder answering the decoder's field-class queries
`timescale 1ns/100ps
`default_nettype none

module cid_sub_model
    import cid_pkg::*;
(
    // Clock
    input wire logic clk_i,
    // Query from the decoder
    input wire cid_sub_req_t sub_req_i,
    // Answer the bench wants given to the next query
    input wire cid_sub_rsp_t plan_i,
    // Answer to the decoder
    output cid_sub_rsp_t sub_rsp_o
);

    ////////////////////////////////////////////////////////////////////////
    // Toggles every cycle so an unasked answer never looks stable
    logic scramble = 1'b0;

    // Free-running scramble phase
    always_ff @(posedge clk_i)
    begin
        scramble <= ~scramble;
    end

    ////////////////////////////////////////////////////////////////////////
    // Answer a field-class query at once, junk otherwise
    always_comb
    begin
        if (sub_req_i.valid)
        begin
            sub_rsp_o = plan_i;
        end
        else
        begin
            // A decoder that reads this outside a query gets garbage
            sub_rsp_o = scramble ? ~plan_i : (plan_i ^ 7'h55);
        end
    end

endmodule // cid_sub_model

`default_nettype wire

// ### test/test_cid_decoder.sv
// Self-checking bench for the compact instruction major-opcode decoder
`timescale 1ns/100ps
`default_nettype none

module test_cid_decoder;
    import cid_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Marked-encoding case: control word, sub answer, expected exceptions
    typedef struct packed {
        logic [9:0] ctrl;
        cid_mark_t mark;
        logic cop;
        logic [1:0] num;
        logic impl;
        logic ri;
        logic cu;
    } cid_tb_row_t;

    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    cid_fetch_t fetch_i = '0;
    cid_sub_req_t sub_req_o;
    cid_sub_rsp_t sub_rsp_i;
    cid_sub_rsp_t plan = '0; // Answer handed to the partner model
    cid_dec_t dec_o;
    logic cyc_i = 1'b0;
    logic stb_i = 1'b0;
    logic we_i = 1'b0;
    logic [3:0] adr_i = 4'h0;
    logic [3:0] sel_i = 4'h0;
    logic [31:0] dat_i = 32'h0;
    logic [31:0] dat_o;
    logic ack_o;
    int mismatches = 0;
    int check_count = 0;

    // Expected result per major opcode; op_none marks a reserved slot
    cid_op_t exp_map [32] = '{
        op_stack_rel_add_imm, op_none, op_none, op_none,
        op_branch_if_zero, op_branch_if_nonzero, op_shift_class, op_none,
        op_two_reg_add_imm_class, op_add_imm_8bit, op_set_less_imm,
        op_set_less_imm_unsigned, op_eight_bit_function_class,
        op_load_immediate, op_compare_immediate, op_none,
        op_load_byte_signed, op_load_half_signed, op_stack_rel_load_word,
        op_load_word, op_load_byte_unsigned, op_load_half_unsigned,
        op_pc_rel_load_word, op_none, op_store_byte, op_store_half,
        op_stack_rel_store_word, op_store_word, op_three_reg_class,
        op_reg_reg_class, op_none, op_none
    };

    // Marked encodings behind the shift class, one row each
    cid_tb_row_t rows [16] = '{
        '{10'h000, mk_none, 1'b0, 2'h0, 1'b0, 1'b0, 1'b0},
        '{10'h000, mk_reserved, 1'b0, 2'h0, 1'b0, 1'b1, 1'b0},
        '{10'h000, mk_higher, 1'b0, 2'h0, 1'b0, 1'b1, 1'b0},
        '{10'h001, mk_compat, 1'b0, 2'h0, 1'b0, 1'b1, 1'b0},
        '{10'h003, mk_compat, 1'b0, 2'h0, 1'b0, 1'b0, 1'b0},
        '{10'h005, mk_compat, 1'b0, 2'h0, 1'b0, 1'b0, 1'b0},
        '{10'h009, mk_compat, 1'b0, 2'h0, 1'b0, 1'b0, 1'b0},
        '{10'h001, mk_compat, 1'b1, 2'h2, 1'b0, 1'b0, 1'b1},
        '{10'h041, mk_compat, 1'b1, 2'h2, 1'b0, 1'b1, 1'b0},
        '{10'h000, mk_partner, 1'b0, 2'h0, 1'b0, 1'b1, 1'b0},
        '{10'h000, mk_partner, 1'b1, 2'h1, 1'b0, 1'b0, 1'b1},
        '{10'h000, mk_partner, 1'b0, 2'h0, 1'b1, 1'b0, 1'b0},
        '{10'h000, mk_debug, 1'b0, 2'h0, 1'b0, 1'b1, 1'b0},
        '{10'h200, mk_debug, 1'b0, 2'h0, 1'b0, 1'b0, 1'b0},
        '{10'h000, mk_ase, 1'b0, 2'h0, 1'b0, 1'b1, 1'b0},
        '{10'h100, mk_ase, 1'b0, 2'h0, 1'b0, 1'b0, 1'b0}
    };

    ////////////////////////////////////////////////////////////////////////
    // 100 MHz clock
    always #5 clk_i = ~clk_i;

    cid_decoder cid_decoder_inst (
        .clk_i(clk_i), .rst_i(rst_i), .fetch_i(fetch_i),
        .sub_req_o(sub_req_o), .sub_rsp_i(sub_rsp_i), .dec_o(dec_o),
        .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
        .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o)
    );

    cid_sub_model cid_sub_model_inst (
        .clk_i(clk_i), .sub_req_i(sub_req_o), .plan_i(plan),
        .sub_rsp_o(sub_rsp_i)
    );

    ////////////////////////////////////////////////////////////////////////
    // Count a comparison, report a mismatch at once
    task automatic compare(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp)
        begin
            mismatches++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Verdict and end of run
    task automatic end_sim();
        if (mismatches == 0 && check_count > 0)
        begin
            $display("[ PASS ]");
        end
        else
        begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // One classic Wishbone cycle; waits for ack with a bounded count
    task automatic wb(input logic w, input logic [3:0] a,
        input logic [3:0] s, input logic [31:0] d, output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= a;
        sel_i <= s;
        dat_i <= d;
        do
        begin
            @(posedge clk_i);
            n++;
        end
        while (ack_o !== 1'b1 && n < 20);
        q = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        if (n >= 20)
        begin
            compare(ack_o, 1'b1);
        end
    endtask

    // Register read compared against an expected word
    task automatic rd_chk(input logic [3:0] a, input logic [31:0] exp);
        logic [31:0] q;
        wb(1'b0, a, 4'hf, 32'h0, q);
        compare(q, exp);
    endtask

    // One fetch; sq: 0 no query, 1 query expected, 2 not checked
    task automatic run_fetch(input logic [31:0] ins, input logic pair,
        input cid_sub_rsp_t rsp, input cid_op_t eop, input logic ri,
        input logic cu, input logic [1:0] sq);
        @(posedge clk_i);
        fetch_i <= '{1'b1, pair, ins};
        plan <= rsp;
        #1;
        if (sq != 2'h2)
        begin
            compare(sub_req_o.valid, sq[0]);
        end
        if (sq == 2'h1)
        begin
            compare(sub_req_o.op, eop);
            compare({sub_req_o.extended, sub_req_o.hw},
                {pair && (ins[31:27] == MAJ_PREFIX),
                (pair && (ins[31:27] != MAJ_PREFIX)) ? ins[31:16]
                : ins[15:0]});
        end
        @(posedge clk_i);
        fetch_i.valid <= 1'b0;
        #1;
        compare({dec_o.valid, dec_o.exc_ri, dec_o.exc_cu, dec_o.commit},
            {1'b1, ri, cu, ~(ri | cu)});
        if (!(ri | cu))
        begin
            compare(dec_o.op, eop);
        end
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial
    begin
        cid_op_t e;
        logic [1:0] sq;
        logic [31:0] q;
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        #1;
        compare({dec_o, ack_o}, 32'h0);
        compare(dat_o, 32'h0);
        rd_chk({OFS_CTRL, 2'b00}, 32'h0);
        rd_chk({OFS_COUNT, 2'b00}, 32'h0);
        // Byte lanes mask control writes
        wb(1'b1, {OFS_CTRL, 2'b00}, 4'h1, 32'hffff_ffff, q);
        rd_chk({OFS_CTRL, 2'b00}, 32'h0ff);
        wb(1'b1, {OFS_CTRL, 2'b00}, 4'h2, 32'h0, q);
        rd_chk({OFS_CTRL, 2'b00}, 32'h0ff);
        wb(1'b1, {OFS_CTRL, 2'b00}, 4'hf, 32'h0, q);
        // Unmapped word: acked, ignored, reads zero
        wb(1'b1, 4'hc, 4'hf, 32'hffff_ffff, q);
        rd_chk(4'hc, 32'h0);
        rd_chk({OFS_CTRL, 2'b00}, 32'h0);
        // Every major opcode as a lone halfword
        for (int m = 0; m < 32; m++)
        begin
            e = exp_map[m];
            sq = (e inside {op_shift_class, op_two_reg_add_imm_class,
                op_eight_bit_function_class, op_three_reg_class,
                op_reg_reg_class}) ? 2'h1 : ((e == op_none) ? 2'h2 : 2'h0);
            run_fetch({16'h0, m[4:0], 11'h0}, 1'b0, '0, e, e == op_none,
                1'b0, sq);
        end
        // Marked encodings; exception counters cleared first
        wb(1'b1, {OFS_COUNT, 2'b00}, 4'h0, 32'h0, q);
        for (int i = 0; i < 16; i++)
        begin
            wb(1'b1, {OFS_CTRL, 2'b00}, 4'hf, {22'h0, rows[i].ctrl}, q);
            run_fetch(32'h3000, 1'b0, '{rows[i].mark, rows[i].cop,
                rows[i].num, rows[i].impl}, op_shift_class, rows[i].ri,
                rows[i].cu, 2'h1);
        end
        rd_chk({OFS_COUNT, 2'b00}, {16'd2, 16'd7});
        wb(1'b1, {OFS_CTRL, 2'b00}, 4'hf, 32'h0, q);
        // Link class selected by bit 26 of the pair
        run_fetch(32'h1800_0000, 1'b1, '0, op_jump_and_link, 1'b0, 1'b0,
            2'h2);
        run_fetch(32'h1c00_0000, 1'b1, '0, op_jump_link_switch_isa, 1'b0,
            1'b0, 2'h2);
        // Prefix in front of good and bad second halfwords
        run_fetch(32'hf000_9800, 1'b1, '0, op_load_word, 1'b0, 1'b0,
            2'h0);
        run_fetch(32'hf000_3000, 1'b1, '{mk_reserved, 1'b0, 2'h0, 1'b0},
            op_shift_class, 1'b1, 1'b0, 2'h1);
        run_fetch(32'hf000_3800, 1'b1, '0, op_none, 1'b1, 1'b0,
            2'h2);
        run_fetch(32'hf000_f000, 1'b1, '0, op_none, 1'b1, 1'b0,
            2'h2);
        run_fetch(32'hf000_1800, 1'b1, '0, op_none, 1'b1, 1'b0,
            2'h2);
        // Status follows the last decode and ignores writes
        run_fetch(32'h9800, 1'b0, '0, op_load_word, 1'b0, 1'b0, 2'h0);
        wb(1'b1, {OFS_STATUS, 2'b00}, 4'hf, 32'hffff_ffff, q);
        rd_chk({OFS_STATUS, 2'b00}, 32'(op_load_word));
        // Second reset in mid-run clears control and counters
        wb(1'b1, {OFS_CTRL, 2'b00}, 4'hf, 32'h3ff, q);
        @(posedge clk_i);
        rst_i <= 1'b1;
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        rd_chk({OFS_CTRL, 2'b00}, 32'h0);
        rd_chk({OFS_COUNT, 2'b00}, 32'h0);
        end_sim();
    end

    // Watchdog well beyond the few hundred cycles the tests need
    initial
    begin
        repeat (5000) @(posedge clk_i);
        mismatches++;
        end_sim();
    end

endmodule // test_cid_decoder

`default_nettype wire
